// File: rpsel_top.sv
// Remappable output pin select for remap_pin_118 and remap_pin_120.
// Assumes a simple register port on clk; read data one cycle after the strobe.
// Contract
// RULE1 - Map register 8 holds pin 118 selector in bits 13..8, read/write, resets zero.
// RULE2 - Map register 9 holds pin 120 selector in bits 5..0, read/write, resets zero.
// RULE3 - Map register 8 bits 15..14 and 7..0 always read zero.
// RULE4 - Map register 9 bits 15..6 always read zero.
// RULE5 - Selector value names the peripheral output routed to the pin.
// RULE6 - Code zero keeps default port; one is first UART, 0x10 first compare.
// RULE7 - Remapped output beats other digital functions but never analog ones.
// RULE8 - No lockout between registers; any mix of selections accepted.
// RULE9 - Unimplemented bit writes ignored; unknown codes keep default port function.
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/100ps
module rpsel_top
  import rpsel_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [RPSEL_AW-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Peripheral outputs and default port drive
  input wire logic [RPSEL_NSRC-1:0] periph_out,
  input wire logic port_out_118,
  input wire logic port_out_120,
  input wire logic analog_en_118,
  input wire logic analog_en_120,
  // Pins
  output logic remap_pin_118,
  output logic remap_pin_120,
  output logic remapped_118,
  output logic remapped_120
);
  typedef struct packed {
    logic [5:0] pin118_output_select;
    logic [5:0] pin120_output_select;
    logic [15:0] rdata;
  } rpsel_state_t;
  rpsel_state_t st;
  rpsel_state_t next_st;

  // ****************************************************
  // Register file
  // ****************************************************
  always_comb begin
    next_st = st;
    next_st.rdata = RPSEL_READ_ZERO;
    // Each register written alone; no cross-checks between them
    if (reg_wr) begin // [RULE8]
      if (reg_addr == RPSEL_ADDR_MAP8) begin
        next_st.pin118_output_select =
          reg_wdata[RPSEL_MAP8_LSB +: RPSEL_SEL_W]; // [RULE1] [RULE9]
      end
      if (reg_addr == RPSEL_ADDR_MAP9) begin
        next_st.pin120_output_select =
          reg_wdata[RPSEL_MAP9_LSB +: RPSEL_SEL_W]; // [RULE2] [RULE9]
      end
    end
    // Unmapped addresses read zero
    if (reg_rd) begin
      if (reg_addr == RPSEL_ADDR_MAP8) begin
        next_st.rdata[RPSEL_MAP8_LSB +: RPSEL_SEL_W] = st.pin118_output_select; // [RULE3]
      end
      if (reg_addr == RPSEL_ADDR_MAP9) begin
        next_st.rdata[RPSEL_MAP9_LSB +: RPSEL_SEL_W] = st.pin120_output_select; // [RULE4]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st.pin118_output_select <= RPSEL_SEL_RESET; // [RULE1]
      st.pin120_output_select <= RPSEL_SEL_RESET; // [RULE2]
      st.rdata <= RPSEL_READ_ZERO;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;

  // ****************************************************
  // Pin multiplexers
  // ****************************************************
  // Registered mux adds one cycle of latency to every pin
  rpsel_pin_mux u_mux_118 (
    .clk(clk),
    .rst(rst),
    .sel(st.pin118_output_select),
    .periph_out(periph_out),
    .port_out(port_out_118),
    .analog_en(analog_en_118),
    .pin_out(remap_pin_118),
    .pin_remapped(remapped_118)
  );

  rpsel_pin_mux u_mux_120 (
    .clk(clk),
    .rst(rst),
    .sel(st.pin120_output_select),
    .periph_out(periph_out),
    .port_out(port_out_120),
    .analog_en(analog_en_120),
    .pin_out(remap_pin_120),
    .pin_remapped(remapped_120)
  );
endmodule

// File: rpsel_pkg.sv
// Package for the remappable output pin select block.
// Assumes a 16-bit register port and peripheral outputs on the same clock.
package rpsel_pkg;
  // ****************************************************
  // Register map
  // ****************************************************
  localparam int RPSEL_AW = 4;
  localparam logic [3:0] RPSEL_ADDR_MAP8 = 4'h8;
  localparam logic [3:0] RPSEL_ADDR_MAP9 = 4'h9;
  localparam logic [15:0] RPSEL_READ_ZERO = 16'h0000;
  // Field positions
  localparam int RPSEL_MAP8_LSB = 8;
  localparam int RPSEL_MAP9_LSB = 0;
  localparam int RPSEL_SEL_W = 6;
  localparam logic [5:0] RPSEL_SEL_RESET = 6'h00;
  // ****************************************************
  // Peripheral output codes
  // ****************************************************
  localparam logic [5:0] RPSEL_CODE_PORT = 6'h00;
  localparam logic [5:0] RPSEL_CODE_UART_ONE_TX = 6'h01;
  localparam logic [5:0] RPSEL_CODE_UART_TWO_TX = 6'h03;
  localparam logic [5:0] RPSEL_CODE_SPI_DATA = 6'h08;
  localparam logic [5:0] RPSEL_CODE_SPI_CLK = 6'h09;
  localparam logic [5:0] RPSEL_CODE_SPI_SEL = 6'h0a;
  localparam logic [5:0] RPSEL_CODE_CAN_TX = 6'h0e;
  localparam logic [5:0] RPSEL_CODE_OCMP_ONE = 6'h10;
  localparam logic [5:0] RPSEL_CODE_OCMP_TWO = 6'h11;
  localparam logic [5:0] RPSEL_CODE_OCMP_THREE = 6'h12;
  localparam logic [5:0] RPSEL_CODE_OCMP_FOUR = 6'h13;
  localparam logic [5:0] RPSEL_CODE_CMPR_ONE = 6'h18;
  localparam logic [5:0] RPSEL_CODE_CMPR_TWO = 6'h19;
  localparam logic [5:0] RPSEL_CODE_CMPR_THREE = 6'h1a;
  localparam logic [5:0] RPSEL_CODE_PWM_SYNC = 6'h2d;
  localparam logic [5:0] RPSEL_CODE_QEI_MATCH = 6'h2f;
  localparam logic [5:0] RPSEL_CODE_REF_CLK = 6'h31;
  localparam logic [5:0] RPSEL_CODE_CMPR_FOUR = 6'h32;
  localparam int RPSEL_NSRC = 17;
  // Code of each source, indexed by its bit in the periph_out vector
  localparam logic [RPSEL_NSRC-1:0][5:0] RPSEL_SRC_CODE = {
    RPSEL_CODE_CMPR_FOUR, RPSEL_CODE_REF_CLK, RPSEL_CODE_QEI_MATCH, RPSEL_CODE_PWM_SYNC,
    RPSEL_CODE_CMPR_THREE, RPSEL_CODE_CMPR_TWO, RPSEL_CODE_CMPR_ONE, RPSEL_CODE_OCMP_FOUR,
    RPSEL_CODE_OCMP_THREE, RPSEL_CODE_OCMP_TWO, RPSEL_CODE_OCMP_ONE, RPSEL_CODE_CAN_TX,
    RPSEL_CODE_SPI_SEL, RPSEL_CODE_SPI_CLK, RPSEL_CODE_SPI_DATA, RPSEL_CODE_UART_TWO_TX,
    RPSEL_CODE_UART_ONE_TX};
endpackage

// File: rpsel_pin_mux.sv
// One pin's output multiplexer, registered.
// Assumes peripheral and port signals are synchronous to clk.
`timescale 1ns/100ps
module rpsel_pin_mux
  import rpsel_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Selection
  input wire logic [5:0] sel,
  input wire logic [RPSEL_NSRC-1:0] periph_out,
  input wire logic port_out,
  input wire logic analog_en,
  // Pin
  output logic pin_out,
  output logic pin_remapped
);
  typedef struct packed {
    logic pin_out;
    logic pin_remapped;
  } rpsel_mux_state_t;
  rpsel_mux_state_t st;
  rpsel_mux_state_t next_st;
  logic hit;
  logic val;

  // ****************************************************
  // Code decode
  // ****************************************************
  always_comb begin
    // Code 0 and unlisted codes match nothing and fall back to the port
    hit = 1'b0; // [RULE9]
    val = 1'b0;
    // Codes are distinct, so at most one source matches
    for (int i = 0; i < RPSEL_NSRC; i++) begin
      if (sel == RPSEL_SRC_CODE[i]) begin // [RULE5] [RULE6]
        hit = 1'b1;
        val = periph_out[i];
      end
    end
  end

  always_comb begin
    next_st = st;
    // Analog use of the pin always outranks remapping
    next_st.pin_remapped = hit && !analog_en; // [RULE7]
    next_st.pin_out = next_st.pin_remapped ? val : port_out; // [RULE7]
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pin_out = st.pin_out;
  assign pin_remapped = st.pin_remapped;
endmodule

// File: rpsel_checker.sv
// Checker on the ports of rpsel_top.
// Assumes one clock domain and a synchronous reset.
`timescale 1ns/100ps
module rpsel_checker
  import rpsel_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [RPSEL_AW-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  // Peripheral outputs and port drive
  input wire logic [RPSEL_NSRC-1:0] periph_out,
  input wire logic port_out_118,
  input wire logic port_out_120,
  input wire logic analog_en_118,
  input wire logic analog_en_120,
  // Pins
  input wire logic remap_pin_118,
  input wire logic remap_pin_120,
  input wire logic remapped_118,
  input wire logic remapped_120
);
  // ****
  // Assertions
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence wr8_s; reg_wr && reg_addr == RPSEL_ADDR_MAP8; endsequence
  sequence wr9_s; reg_wr && reg_addr == RPSEL_ADDR_MAP9; endsequence
  sequence rd8_s; reg_rd && reg_addr == RPSEL_ADDR_MAP8; endsequence
  sequence rd9_s; reg_rd && reg_addr == RPSEL_ADDR_MAP9; endsequence
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  map8_unused_a: assert property (rd8_s |=> (reg_rdata & 16'hc0ff) == 16'h0000)
    else $error("map 8 unused bits not zero");
  map9_unused_a: assert property (rd9_s |=> reg_rdata[15:6] == 10'h000)
    else $error("map 9 unused bits not zero");
  map8_back_a: assert property (wr8_s ##1 rd8_s |=>
    reg_rdata == ($past(reg_wdata, 2) & 16'h3f00)) else $error("map 8 readback wrong");
  map9_back_a: assert property (wr9_s ##1 rd9_s |=>
    reg_rdata == ($past(reg_wdata, 2) & 16'h003f)) else $error("map 9 readback wrong");
  uart_route_a: assert property (wr8_s and reg_wdata[13:8] == RPSEL_CODE_UART_ONE_TX
    ##1 !analog_en_118 |=> remap_pin_118 == $past(periph_out[0]) && remapped_118)
    else $error("uart not routed to pin 118");
  analog_wins_a: assert property (analog_en_118 |=>
    remap_pin_118 == $past(port_out_118) && !remapped_118) else $error("analog lost");
  port_default_a: assert property (!$past(rst) && !remapped_118 |->
    remap_pin_118 == $past(port_out_118)) else $error("pin 118 not on port");
endmodule
bind rpsel_top rpsel_checker i_chk(.clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
  .reg_rdata, .periph_out, .port_out_118, .port_out_120, .analog_en_118, .analog_en_120,
  .remap_pin_118, .remap_pin_120, .remapped_118, .remapped_120);

// File: rpsel_tb_top.sv
// Testbench for rpsel_top: register access and pin routing.
// Assumes the checker is bound in from its own file.
`timescale 1ns/100ps
module rpsel_tb_top
  import rpsel_pkg::*;
;
  logic clk = '0, rst = '1, reg_wr = '0, reg_rd = '0;
  logic [RPSEL_AW-1:0] reg_addr = '0;
  logic [15:0] reg_wdata = '0, reg_rdata;
  logic [RPSEL_NSRC-1:0] periph_out = '0;
  logic port_out_118 = '0, port_out_120 = '0, analog_en_118 = '0, analog_en_120 = '0;
  logic remap_pin_118, remap_pin_120, remapped_118, remapped_120;
  int miscompares = 0, compares = 0;
  // Codes in periph_out bit order
  logic [5:0] codes [17] = '{6'h01, 6'h03, 6'h08, 6'h09, 6'h0a, 6'h0e, 6'h10, 6'h11,
    6'h12, 6'h13, 6'h18, 6'h19, 6'h1a, 6'h2d, 6'h2f, 6'h31, 6'h32};
  rpsel_top i_dut(.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .periph_out, .port_out_118, .port_out_120, .analog_en_118, .analog_en_120,
    .remap_pin_118, .remap_pin_120, .remapped_118, .remapped_120);
  initial forever #20 clk = ~clk;
  // ****
  // Tasks
  // ****
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Step past the edge so a following call never drives the strobe twice at once
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'h0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 check(reg_rdata, exp);
  endtask
  // Bits: pin118, remapped118, pin120, remapped120
  task automatic pins(input logic [3:0] exp);
    repeat (2) @(posedge clk);
    #1 check({12'h000, remap_pin_118, remapped_118, remap_pin_120, remapped_120},
      {12'h000, exp});
  endtask
  task automatic report_and_stop;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    #50000 miscompares++;
    report_and_stop;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    rd(RPSEL_ADDR_MAP8, 16'h0000);
    rd(RPSEL_ADDR_MAP9, 16'h0000);
    wr(RPSEL_ADDR_MAP8, 16'hffff);
    rd(RPSEL_ADDR_MAP8, 16'h3f00);
    wr(RPSEL_ADDR_MAP9, 16'hffff);
    rd(RPSEL_ADDR_MAP9, 16'h003f);
    rd(4'h3, 16'h0000);
    periph_out <= '1;
    port_out_118 <= 1'h1;
    pins(4'h8);
    for (int i = 0; i < 17; i++) begin
      periph_out <= 17'h00001 << i;
      wr(RPSEL_ADDR_MAP9, {10'h000, codes[i]});
      pins(4'hb);
      periph_out <= ~(17'h00001 << i);
      pins(4'h9);
    end
    periph_out <= 17'h00001;
    port_out_118 <= 1'h0;
    wr(RPSEL_ADDR_MAP8, 16'h0100);
    pins(4'hd);
    wr(RPSEL_ADDR_MAP9, 16'h0001);
    pins(4'hf);
    analog_en_118 <= 1'h1;
    analog_en_120 <= 1'h1;
    port_out_120 <= 1'h1;
    pins(4'h2);
    analog_en_118 <= 1'h0;
    analog_en_120 <= 1'h0;
    wr(RPSEL_ADDR_MAP8, 16'h0000);
    rd(RPSEL_ADDR_MAP9, 16'h0001);
    pins(4'h3);
    // Mid-run reset must clear a selector that is in use
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    rd(RPSEL_ADDR_MAP9, 16'h0000);
    pins(4'h2);
    report_and_stop;
  end
endmodule
